// ### chop_ctrl.sv
/*
 * Chopper control for a two-winding bipolar stepper bridge, with charge pump
 * sequencing, overcurrent shutdown and supply-monitor reset, plus an APB slave.
 * Assumes all pins except APB are asynchronous and are double-registered here.
 */
// Functional notes
// - Forward current: charge is upper-left+lower-right, slow is both lowers, fast is upper-right+lower-left.
// - Reverse current: charge is upper-right+lower-left, slow is both lowers, fast is upper-left+lower-right.
// - Charge, slow and fast decay follow each other automatically to hold current constant.
// - Enable low turns all four switches of that winding off together.
// - Decay is done with switches actively on so body diodes carry no current.
// - One chopping period is eight oscillator cycles.
// - Overcurrent is ignored for a four-cycle dead time and shuts down within five cycles plus sync.
// - Undervoltage on either supply while the other is present applies internal reset, outputs off.
// - After reset the pump runs switch one on then switch two on, stopping once boosted enough.
// - When the pumped level drops the pump resumes its two-step sequence.
// - After overcurrent shutdown the part stays off with pump halted until standby goes low then high.
// - The mixed-decay fraction is 37.5 percent of the chopping period.
`timescale 1ns/100ps
module chop_ctrl
   import chop_pkg::*;
(
   input  wire logic                    CLOCK_I,
   input  wire logic                    ARST_N_I,
   input  wire logic                    OSC_I,
   input  wire logic                    STANDBY_N_I,
   input  wire chop_pkg::winding_in_type WIND_A_I,
   input  wire chop_pkg::winding_in_type WIND_B_I,
   input  wire logic                    OVERCURRENT_I,
   input  wire logic                    LOGIC_SUPPLY_TRIP_I,
   input  wire logic                    MOTOR_SUPPLY_TRIP_I,
   input  wire logic                    PUMP_LOW_I,
   input  wire logic                    PSEL_I,
   input  wire logic                    PENABLE_I,
   input  wire logic                    PWRITE_I,
   input  wire logic [11:0]             PADDR_I,
   input  wire logic [31:0]             PWDATA_I,
   output logic [31:0]                  PRDATA_O,
   output logic                         PREADY_O,
   output logic                         PSLVERR_O,
   output chop_pkg::gates_type          GATES_A_O,
   output chop_pkg::gates_type          GATES_B_O,
   output logic                         PUMP_SWITCH_FIRST_O,
   output logic                         PUMP_SWITCH_SECOND_O,
   output logic                         OVERCURRENT_SHUTDOWN_O
);
   import chop_pkg::*;

   logic                rst_meta_q;
   logic                rst_sync_q;
   logic                rst_n;

   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // Two-flop synchronisers for every pin input except APB
   localparam int unsigned NSYNC = 12;
   logic [NSYNC-1:0]    pin_raw;
   logic [NSYNC-1:0]    pin_meta_q;
   logic [NSYNC-1:0]    pin_q;

   assign pin_raw = {OSC_I, STANDBY_N_I, WIND_A_I, WIND_B_I, OVERCURRENT_I,
                     LOGIC_SUPPLY_TRIP_I, MOTOR_SUPPLY_TRIP_I, PUMP_LOW_I};

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= '0;
         pin_q      <= '0;
      end else begin
         pin_meta_q <= pin_raw;
         pin_q      <= pin_meta_q;
      end
   end

   logic                osc_s;
   logic                standby_n_s;
   winding_in_type      wind_a_s;
   winding_in_type      wind_b_s;
   logic                overcurrent_s;
   logic                logic_trip_s;
   logic                motor_trip_s;
   logic                pump_low_s;

   assign {osc_s, standby_n_s, wind_a_s, wind_b_s, overcurrent_s,
           logic_trip_s, motor_trip_s, pump_low_s} = pin_q;

   // Register bus
   logic [31:0]         ctrl_q;
   logic                apb_wr;
   logic                apb_rd;
   logic                addr_ok;

   assign addr_ok = (PADDR_I == CTRL_ADDR) || (PADDR_I == STATUS_ADDR);
   assign apb_wr  = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
   assign apb_rd  = PSEL_I && !PENABLE_I && !PWRITE_I;

   // Internal reset: either supply monitor, or software/pin standby
   logic                uv_reset;
   logic                standby_req;
   assign uv_reset    = logic_trip_s || motor_trip_s;
   assign standby_req = !standby_n_s || !ctrl_q[CTRL_STANDBY_N];

   // Oscillator edge and position inside the chopping period
   logic                osc_last_q;
   logic                osc_tick;
   logic [2:0]          phase_q;

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         osc_last_q <= 1'b0;
      end else begin
         osc_last_q <= osc_s;
      end
   end
   assign osc_tick = osc_s && !osc_last_q;

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= PHASE_RESET;
      end else if (osc_tick) begin
         phase_q <= phase_q + 3'h1;
      end
   end

   logic                period_start;
   logic                fast_window;
   assign period_start = osc_tick && (phase_q == 3'(OSC_PER_CHOP - 1));
   assign fast_window  = phase_q >= 3'(OSC_PER_CHOP - FAST_OSC_CYCLES);

   // Overcurrent latch with dead time counted in oscillator cycles
   logic [2:0]          dead_q;
   logic                shutdown_q;
   logic                standby_prev_q;

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         dead_q <= DEAD_RESET;
      end else if (!overcurrent_s || shutdown_q) begin
         dead_q <= DEAD_RESET;
      end else if (osc_tick && dead_q != 3'(OCP_DEAD_CYCLES + 1)) begin
         dead_q <= dead_q + 3'h1;
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         standby_prev_q <= 1'b1;
      end else begin
         standby_prev_q <= standby_req;
      end
   end

   // Latched until standby goes active and then releases again
   // The first counted edge only closes a partial cycle, so one extra edge
   // keeps the dead time at four whole oscillator cycles at the least
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         shutdown_q <= 1'b0;
      end else if (dead_q == 3'(OCP_DEAD_CYCLES + 1)) begin
         shutdown_q <= 1'b1;
      end else if (standby_prev_q && !standby_req) begin
         shutdown_q <= 1'b0;
      end
   end

   logic                halted;
   assign halted = uv_reset || standby_req || shutdown_q;

   // Per-winding chopper state
   function automatic gates_type map_gates(input bridge_state_type st, input logic fwd);
      gates_type g;
      g = GATES_OFF;
      unique case (st)
         ST_OFF:    g = GATES_OFF;
         ST_CHARGE: g = fwd ? 4'b1001 : 4'b0110;
         ST_SLOW:   g = 4'b0011;
         ST_FAST:   g = fwd ? 4'b0110 : 4'b1001;
      endcase
      return g;
   endfunction : map_gates

   function automatic bridge_state_type next_state(input bridge_state_type st,
                                                   input winding_in_type  w);
      bridge_state_type n;
      n = st;
      if (!w.enable) begin
         n = ST_OFF;
      end else if (period_start) begin
         n = ST_CHARGE;
      end else if (fast_window) begin
         n = ST_FAST;
      end else if (st == ST_CHARGE && w.current_trip) begin
         n = ST_SLOW;
      end else if (st == ST_OFF) begin
         n = ST_CHARGE;
      end
      return n;
   endfunction : next_state

   bridge_state_type    st_a_q;
   bridge_state_type    st_b_q;

   // Windings run independently but share the period, so both chop in step
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         st_a_q <= ST_OFF;
      end else if (halted) begin
         st_a_q <= ST_OFF;
      end else begin
         st_a_q <= next_state(st_a_q, wind_a_s);
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         st_b_q <= ST_OFF;
      end else if (halted) begin
         st_b_q <= ST_OFF;
      end else begin
         st_b_q <= next_state(st_b_q, wind_b_s);
      end
   end

   // Gates registered from the state; phase picks the mapping
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         GATES_A_O <= GATES_OFF;
      end else if (halted) begin
         GATES_A_O <= GATES_OFF;
      end else begin
         GATES_A_O <= map_gates(st_a_q, wind_a_s.phase);
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         GATES_B_O <= GATES_OFF;
      end else if (halted) begin
         GATES_B_O <= GATES_OFF;
      end else begin
         GATES_B_O <= map_gates(st_b_q, wind_b_s.phase);
      end
   end

   // Charge pump: alternate while the pumped level is low, one oscillator cycle per step
   logic                pump_step_q;
   logic                pump_run_q;

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         pump_run_q  <= 1'b0;
         pump_step_q <= 1'b0;
      end else if (halted) begin
         pump_run_q  <= 1'b0;
         pump_step_q <= 1'b0;
      end else if (osc_tick) begin
         if (!pump_run_q) begin
            pump_run_q  <= pump_low_s;
            pump_step_q <= 1'b0;
         end else if (pump_step_q) begin
            pump_run_q  <= pump_low_s;
            pump_step_q <= 1'b0;
         end else begin
            pump_step_q <= 1'b1;
         end
      end
   end

   // Both switches come from one step bit, so they can never overlap
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         PUMP_SWITCH_FIRST_O  <= 1'b0;
         PUMP_SWITCH_SECOND_O <= 1'b0;
      end else begin
         PUMP_SWITCH_FIRST_O  <= pump_run_q && !halted && !pump_step_q;
         PUMP_SWITCH_SECOND_O <= pump_run_q && !halted && pump_step_q;
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         OVERCURRENT_SHUTDOWN_O <= 1'b0;
      end else begin
         OVERCURRENT_SHUTDOWN_O <= shutdown_q;
      end
   end

   // Apb: zero-wait writes and reads; read data is registered in the setup cycle
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (apb_wr && PADDR_I == CTRL_ADDR) begin
         ctrl_q <= {30'h0, PWDATA_I[CTRL_TWO_PHASE], PWDATA_I[CTRL_STANDBY_N]};
      end
   end

   // Status word built field by field so the layout lives in the package
   logic [31:0]         status_word;

   always_comb begin
      status_word                        = STATUS_RESET;
      status_word[STAT_PHASE_LSB +: 3]   = phase_q;
      status_word[STAT_HALTED]           = halted;
      status_word[STAT_STATE_A_LSB +: 2] = st_a_q;
      status_word[STAT_STATE_B_LSB +: 2] = st_b_q;
      status_word[STAT_SHUTDOWN]         = shutdown_q;
      status_word[STAT_UNDERVOLT]        = uv_reset;
      status_word[STAT_PUMP_RUN]         = pump_run_q;
   end

   // Ready follows every setup cycle, so the access phase never stretches
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O  <= PSEL_I && !PENABLE_I;
         PSLVERR_O <= PSEL_I && !PENABLE_I && !addr_ok;
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (apb_rd) begin
         unique case (PADDR_I)
            CTRL_ADDR:   PRDATA_O <= ctrl_q;
            STATUS_ADDR: PRDATA_O <= status_word;
            default:     PRDATA_O <= 32'h0000_0000;
         endcase
      end
   end

endmodule : chop_ctrl

// ### chop_pkg.sv
/*
 * Shared constants and types for the two-winding bridge chopper control.
 * Assumes a single 250 MHz system clock; the RC oscillator arrives as a pin.
 */
package chop_pkg;

   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned OSC_PER_CHOP     = 8;
   localparam int unsigned FAST_OSC_CYCLES  = 3;   // 3 of 8 = 37.5 %
   localparam int unsigned OCP_DEAD_CYCLES  = 4;
   localparam int unsigned PUMP_PHASE_OSC   = 1;
   localparam logic [2:0]  PHASE_RESET      = 3'h0;
   localparam logic [2:0]  DEAD_RESET       = 3'h0;
   localparam logic [3:0]  GATES_OFF        = 4'h0;

   // Apb register map
   localparam logic [11:0] CTRL_ADDR        = 12'h000;
   localparam logic [11:0] STATUS_ADDR      = 12'h004;
   localparam int unsigned CTRL_STANDBY_N   = 0;
   localparam int unsigned CTRL_TWO_PHASE   = 1;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
   localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;

   // Status word field positions
   localparam int unsigned STAT_PHASE_LSB   = 0;
   localparam int unsigned STAT_HALTED      = 3;
   localparam int unsigned STAT_STATE_A_LSB = 4;
   localparam int unsigned STAT_STATE_B_LSB = 6;
   localparam int unsigned STAT_SHUTDOWN    = 8;
   localparam int unsigned STAT_UNDERVOLT   = 9;
   localparam int unsigned STAT_PUMP_RUN    = 10;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_CHARGE,
      ST_SLOW,
      ST_FAST
   } bridge_state_type;

   // Gate set of one winding: high_side_left, high_side_right, low_side_left, low_side_right
   typedef struct packed {
      logic high_side_left;
      logic high_side_right;
      logic low_side_left;
      logic low_side_right;
   } gates_type;

   typedef struct packed {
      logic enable;
      logic phase;
      logic current_trip;
   } winding_in_type;

endpackage : chop_pkg

// ### chop_ctrl_asserts.sv
/* Checker for chop_ctrl: gate patterns, halts, pump order and shutdown.
   Assumes it is bound to chop_ctrl and sees only its ports. */
`timescale 1ns/100ps
module chop_ctrl_asserts
   import chop_pkg::*;
(
   input wire logic           CLOCK_I,
   input wire logic           ARST_N_I,
   input wire logic           OSC_I,
   input wire logic           STANDBY_N_I,
   input wire winding_in_type WIND_A_I,
   input wire logic           OVERCURRENT_I,
   input wire logic           LOGIC_SUPPLY_TRIP_I,
   input wire logic           MOTOR_SUPPLY_TRIP_I,
   input wire gates_type      GATES_A_O,
   input wire gates_type      GATES_B_O,
   input wire logic           PUMP_SWITCH_FIRST_O,
   input wire logic           PUMP_SWITCH_SECOND_O,
   input wire logic           OVERCURRENT_SHUTDOWN_O
);
   logic [3:0] ga;
   logic [3:0] gb;
   logic       osc_q;
   logic [3:0] oc_edges_q;
   assign ga = GATES_A_O;
   assign gb = GATES_B_O;
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) osc_q <= 1'b0;
      else osc_q <= OSC_I;
   end
   // Raw pin edges lead the synced ones, so while the raw pin stays high this count never lags the design
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) oc_edges_q <= 4'h0;
      else if (!OVERCURRENT_I) oc_edges_q <= 4'h0;
      else if (OSC_I && !osc_q && oc_edges_q != 4'hF) oc_edges_q <= oc_edges_q + 4'h1;
   end
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!ARST_N_I);
   pump_exclusive_a: assert property (!(PUMP_SWITCH_FIRST_O && PUMP_SWITCH_SECOND_O))
      else $error("pump switches on together");
   pump_order_a: assert property ($rose(PUMP_SWITCH_SECOND_O) |-> $past(PUMP_SWITCH_FIRST_O))
      else $error("second pump switch without first");
   gates_a_legal_a: assert property (ga inside {4'h0, 4'h3, 4'h6, 4'h9})
      else $error("illegal gate set on winding a");
   gates_b_legal_a: assert property (gb inside {4'h0, 4'h3, 4'h6, 4'h9})
      else $error("illegal gate set on winding b");
   enable_off_a: assert property ((!WIND_A_I.enable) [*6] |-> ga == 4'h0)
      else $error("winding a driven while disabled");
   uv_off_a: assert property ((LOGIC_SUPPLY_TRIP_I || MOTOR_SUPPLY_TRIP_I) [*6] |->
      ga == 4'h0 && gb == 4'h0 && !PUMP_SWITCH_FIRST_O && !PUMP_SWITCH_SECOND_O)
      else $error("outputs on during undervoltage");
   oc_dead_a: assert property ($rose(OVERCURRENT_SHUTDOWN_O) |-> oc_edges_q >= 4'h5)
      else $error("shutdown inside dead time");
   sd_hold_a: assert property (OVERCURRENT_SHUTDOWN_O && STANDBY_N_I && $past(STANDBY_N_I, 4)
      |=> OVERCURRENT_SHUTDOWN_O) else $error("shutdown cleared without standby");
   sd_off_a: assert property (OVERCURRENT_SHUTDOWN_O [*5] |-> ga == 4'h0 && gb == 4'h0
      && !PUMP_SWITCH_FIRST_O && !PUMP_SWITCH_SECOND_O) else $error("outputs on in shutdown");
   cover property ($rose(OVERCURRENT_SHUTDOWN_O));
   cover property ($rose(PUMP_SWITCH_SECOND_O));
   cover property (ga == 4'h3);
endmodule : chop_ctrl_asserts
bind chop_ctrl chop_ctrl_asserts u_chk (.CLOCK_I, .ARST_N_I, .OSC_I, .STANDBY_N_I, .WIND_A_I,
   .OVERCURRENT_I, .LOGIC_SUPPLY_TRIP_I, .MOTOR_SUPPLY_TRIP_I, .GATES_A_O, .GATES_B_O,
   .PUMP_SWITCH_FIRST_O, .PUMP_SWITCH_SECOND_O, .OVERCURRENT_SHUTDOWN_O);

// ### step_partner.sv
/* Step sequencer and RC oscillator model driving the chopper's pins.
   Assumes the bench paces it from the system clock and its reset. */
`timescale 1ns/100ps
module step_partner
   import chop_pkg::*;
#(
   parameter int OSC_HALF = 8,
   parameter int SETTLE   = 40
)(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       standby_n_i,
   input  wire logic       step_i,
   input  wire logic [1:0] en_i,
   input  wire logic [1:0] trip_i,
   output logic            osc_o,
   output logic            standby_n_o,
   output logic            ready_o,
   output winding_in_type  wind_a_o,
   output winding_in_type  wind_b_o
);
   int         div_q;
   int         wait_q;
   logic [1:0] pos_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q <= 0;
         osc_o <= 1'b0;
      end else if (div_q == OSC_HALF - 1) begin
         div_q <= 0;
         osc_o <= ~osc_o;
      end else div_q <= div_q + 1;
   end
   // Drive stays masked until the pump has had time to settle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) wait_q <= 0;
      else if (!standby_n_i) wait_q <= 0;
      else if (wait_q < SETTLE) wait_q <= wait_q + 1;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) pos_q <= 2'h0;
      else if (step_i) pos_q <= pos_q + 2'h1;
   end
   assign standby_n_o = standby_n_i;
   assign ready_o     = (wait_q == SETTLE);
   assign wind_a_o    = '{en_i[0] & ready_o, ~pos_q[1], trip_i[0]};
   assign wind_b_o    = '{en_i[1] & ready_o, ~(pos_q[1] ^ pos_q[0]), trip_i[1]};
endmodule : step_partner

// ### stepper_hbridge_chopper_control_bench.sv
/* Self-checking bench for chop_ctrl with an APB master and a step partner.
   Assumes the partner makes the oscillator at one rising edge per P clocks. */
`timescale 1ns/100ps
module stepper_hbridge_chopper_control_bench;
   import chop_pkg::*;
   localparam int P = 16;
   logic clk = 0, arst_n = 0, osc, stby, rdy, req_n = 1, step = 0, oc = 0, lt = 0, mt = 0;
   logic plow = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, pf, ps, sd;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [1:0]  en = 2'h0, trip = 2'h0, pos = 2'h0;
   logic [3:0]  g_exp, fast, chg;
   gates_type   ga, gb;
   winding_in_type wa, wb;
   int n_mismatch = 0, comparisons = 0, cyc = 0, k, n, len_f, len_c;
   always #2 clk = ~clk;
   step_partner #(.OSC_HALF(P/2), .SETTLE(40)) u_far (.clk_i(clk), .rst_n_i(arst_n),
      .standby_n_i(req_n), .step_i(step), .en_i(en), .trip_i(trip), .osc_o(osc),
      .standby_n_o(stby), .ready_o(rdy), .wind_a_o(wa), .wind_b_o(wb));
   chop_ctrl u_dut (.CLOCK_I(clk), .ARST_N_I(arst_n), .OSC_I(osc), .STANDBY_N_I(stby),
      .WIND_A_I(wa), .WIND_B_I(wb), .OVERCURRENT_I(oc), .LOGIC_SUPPLY_TRIP_I(lt),
      .MOTOR_SUPPLY_TRIP_I(mt), .PUMP_LOW_I(plow), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .GATES_A_O(ga), .GATES_B_O(gb),
      .PUMP_SWITCH_FIRST_O(pf), .PUMP_SWITCH_SECOND_O(ps), .OVERCURRENT_SHUTDOWN_O(sd));
   task finish_test;
      if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic cond(input int s);
      case (s)
         0: cond = (ga === g_exp);
         1: cond = (sd === 1'b1);
         2: cond = (pf === 1'b1);
         3: cond = (ps === 1'b1);
         default: cond = (rdy === 1'b1);
      endcase
   endfunction : cond
   // Charge and fast decay use opposite diagonals, and polarity swaps them
   function automatic logic [3:0] drive_set(input logic charge, input logic fwd);
      drive_set = (charge ^ fwd) ? 4'h6 : 4'h9;
   endfunction : drive_set
   task wait_for(input int s, input int lim);
      n = 0;
      while (!cond(s) && n < lim) begin
         @(posedge clk);
         n++;
      end
      check(32'(cond(s)), 32'h1);
   endtask : wait_for
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] er,
            input logic ee);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      if (!w) check(prdata, er);
      check(32'(pslverr), 32'(ee));
      {psel, penable} <= 2'b00;
   endtask : apb
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      void'($urandom(32'hDA8D));
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, CTRL_ADDR, 32'h0, CTRL_RESET, 1'b0);
      apb(1'b1, CTRL_ADDR, 32'h3, 32'h0, 1'b0);
      apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF, 32'h0, 1'b0);
      apb(1'b0, CTRL_ADDR, 32'h0, 32'h3, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'hFFC, 32'h1, 32'h0, 1'b1);
      wait_for(4, 200);
      en <= 2'h3;
      for (k = 0; k < 4; k++) begin
         n = $urandom_range(1, 3);
         repeat (n) begin
            @(posedge clk) step <= 1'b1;
            pos = pos + 2'h1;
            @(posedge clk) step <= 1'b0;
         end
         fast = drive_set(1'b0, !pos[1]);
         chg = drive_set(1'b1, !pos[1]);
         g_exp = fast;
         wait_for(0, 20 * P);
         g_exp = chg;
         wait_for(0, 20 * P);
         g_exp = fast;
         wait_for(0, 10 * P);
         for (len_f = 0; ga === fast && len_f < 20 * P; len_f++) @(posedge clk);
         check(ga, chg);
         check(gb, drive_set(1'b1, !(pos[1] ^ pos[0])));
         for (len_c = 0; ga === chg && len_c < 20 * P; len_c++) @(posedge clk);
         check((len_f + P / 2) / P, 3);
         check((len_f + len_c + P / 2) / P, 8);
         trip <= 2'h1;
         g_exp = 4'h3;
         wait_for(0, 9 * P);
         trip <= 2'h0;
      end
      en <= 2'h2;
      repeat (8) @(posedge clk);
      check(ga, 4'h0);
      apb(1'b1, CTRL_ADDR, 32'h2, 32'h0, 1'b0);
      repeat (8) @(posedge clk);
      check(gb, 4'h0);
      apb(1'b1, CTRL_ADDR, 32'h3, 32'h0, 1'b0);
      en <= 2'h3;
      if ($urandom_range(0, 1)) lt <= 1'b1;
      else mt <= 1'b1;
      repeat (8) @(posedge clk);
      check({ga, gb, pf, ps}, 10'h0);
      {lt, mt, plow} <= 3'b001;
      wait_for(2, 4 * P);
      wait_for(3, 4 * P);
      plow <= 1'b0;
      repeat (4 * P) @(posedge clk);
      check({pf, ps}, 2'h0);
      plow <= 1'b1;
      wait_for(2, 4 * P);
      {plow, oc} <= 2'b01;
      wait_for(1, 9 * P + 8);
      check(32'(n >= 4 * P), 32'h1);
      oc <= 1'b0;
      repeat (8) @(posedge clk);
      check({ga, gb, pf, ps, sd}, 11'h1);
      req_n <= 1'b0;
      repeat (10) @(posedge clk);
      req_n <= 1'b1;
      repeat (8) @(posedge clk);
      check(sd, 1'b0);
      finish_test();
   end
endmodule : stepper_hbridge_chopper_control_bench
